// ### core/lhb_hub.sv
// loop hub port bypass: seven-port ring forwarding, bypass, indicators
// assumes AXI4-Lite master on clock, transceiver pins asynchronous
`timescale 1ns/1ps
module lhb_hub
  import lhb_pkg::*;
(
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // transceiver module status pins
  input  wire logic [6:0]  module_presence_detect,
  input  wire logic [6:0]  tx_fault,
  input  wire logic [6:0]  rx_signal_loss,
  // serial streams
  input  wire logic [6:0]  rx_serial,
  output logic [6:0]       tx_serial,
  // indicators and interrupt
  output logic [6:0]       led_green,
  output logic [6:0]       led_amber,
  output logic             irq
);
`include "lhb_map.svh"

  lhb_state_t s_reg;
  lhb_state_t s_next;

  lhb_port_t  present;
  lhb_port_t  fault_s;
  lhb_port_t  los_s;
  lhb_port_t  rx_s;
  lhb_port_t  stream_ok;
  lhb_port_t  byp_cond;
  lhb_port_t  fwd;
  lhb_ev_t    ev;
  lhb_port_t  cause_absent;
  lhb_port_t  cause_fault;
  lhb_port_t  cause_los;
  lhb_port_t  cause_stream;
  lhb_port_t  cause_force;
  lhb_port_t  ins_ev;
  lhb_port_t  byp_ev;
  lhb_port_t  inserted;
  lhb_port_t  mod_bad;
  lhb_port_t  lamp_green;
  lhb_port_t  lamp_amber;
  logic       aw_fire;
  logic       w_fire;
  logic       b_fire;
  logic       wr_fire;
  logic       ar_fire;
  logic       r_fire;

  // status pins and streams pass two flops before use
  lhb_sync #(.W(`LHB_NPORT)) u_sync_pres (
    .clock (clock),
    .nrst  (nrst),
    .din   (module_presence_detect),
    .dout  (present)
  );

  lhb_sync #(.W(`LHB_NPORT)) u_sync_fault (
    .clock (clock),
    .nrst  (nrst),
    .din   (tx_fault),
    .dout  (fault_s)
  );

  lhb_sync #(.W(`LHB_NPORT)) u_sync_los (
    .clock (clock),
    .nrst  (nrst),
    .din   (rx_signal_loss),
    .dout  (los_s)
  );

  lhb_sync #(.W(`LHB_NPORT)) u_sync_rx (
    .clock (clock),
    .nrst  (nrst),
    .din   (rx_serial),
    .dout  (rx_s)
  );

  // one monitor per port so a bad stream only affects its own port
  for (genvar g = 0; g < `LHB_NPORT; g++) begin : g_mon
    lhb_stream_mon u_mon (
      .clock (clock),
      .nrst  (nrst),
      .rx    (rx_s[g]),
      .valid (stream_ok[g])
    );
  end

  // causes kept apart; each one alone is enough for bypass
  assign cause_absent = ~present;
  assign cause_fault  = fault_s;
  assign cause_los    = los_s;
  assign cause_stream = ~stream_ok;
  assign cause_force  = s_reg.force_byp;

  // insertion needs every cause clear at once
  assign byp_cond = cause_absent
                  | cause_fault
                  | cause_los
                  | cause_stream
                  | cause_force;

  // status word views
  assign inserted = ~s_reg.bypass;
  assign mod_bad  = cause_fault | cause_los;

  // a port only raises an event when its own decision flips
  assign ins_ev = s_reg.bypass & ~byp_cond;
  assign byp_ev = ~s_reg.bypass & byp_cond;

  assign ev[`LHB_EV_INS_LSB +: 7] = ins_ev;
  assign ev[7]                    = 1'b0;
  assign ev[`LHB_EV_BYP_LSB +: 7] = byp_ev;
  assign ev[15]                   = 1'b0;

  // green follows the module alone; a lost or bad stream leaves it lit
  assign lamp_green = present & ~fault_s;
  // absent module shows both off, so amber is gated by presence
  assign lamp_amber = byp_cond & present;

  // ring walk: each tx takes rx of the nearest inserted port behind it;
  // bypassed ports are never a source, so their data stays out of the loop
  always_comb begin
    int idx;
    logic found;
    idx   = 0;
    found = 1'b0;
    fwd   = '0;
    for (int j = 0; j < `LHB_NPORT; j++) begin
      found = 1'b0;
      for (int k = 1; k <= `LHB_NPORT; k++) begin
        idx = (j >= k) ? j - k : j + `LHB_NPORT - k;
        if (!found && !s_reg.bypass[idx]) begin
          fwd[j] = rx_s[idx];
          found  = 1'b1;
        end
      end
    end
  end

  function automatic logic [31:0] strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    return a == `LHB_ADDR_STATUS || a == `LHB_ADDR_FORCE
        || a == `LHB_ADDR_ISTAT || a == `LHB_ADDR_IMASK;
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] a,
                                            input lhb_state_t st,
                                            input lhb_port_t pres,
                                            input lhb_port_t ok,
                                            input lhb_port_t ins,
                                            input lhb_port_t bad);
    logic [31:0] d;
    d = '0;
    unique case (a)
      `LHB_ADDR_STATUS: begin
        d[`LHB_ST_PRES_LSB +: 7]  = pres;
        d[`LHB_ST_INS_LSB +: 7]   = ins;
        d[`LHB_ST_VALID_LSB +: 7] = ok;
        d[`LHB_ST_FAULT_LSB +: 7] = bad;
      end
      `LHB_ADDR_FORCE: begin
        d[6:0] = st.force_byp;
      end
      `LHB_ADDR_ISTAT: begin
        d[15:0] = st.int_stat;
      end
      `LHB_ADDR_IMASK: begin
        d[15:0] = st.int_mask;
      end
      default: begin
        d = '0;
      end
    endcase
    return d;
  endfunction

  // channel handshakes completing at the coming edge
  assign aw_fire = s_reg.awready && s_axi_awvalid;
  assign w_fire  = s_reg.wready && s_axi_wvalid;
  assign b_fire  = s_reg.bvalid && s_axi_bready;
  // the write waits until both halves are held and the last answer is gone
  assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
  assign ar_fire = s_reg.arready && s_axi_arvalid;
  assign r_fire  = s_reg.rvalid && s_axi_rready;

  always_comb begin
    logic [31:0] m;
    logic [31:0] upd;
    logic [15:0] clr;
    m      = '0;
    upd    = '0;
    clr    = '0;
    s_next = s_reg;

    // write address and data are taken independently
    if (aw_fire) begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (w_fire) begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (b_fire) begin
      s_next.bvalid = 1'b0;
    end

    // both halves held: perform the write and raise the response
    if (wr_fire) begin
      m              = strb_mask(s_reg.w_strb);
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      if (is_mapped(s_reg.aw_addr)) begin
        s_next.bresp = `LHB_RESP_OKAY;
      end else begin
        // unmapped: nothing written, error answer
        s_next.bresp = `LHB_RESP_SLVERR;
      end
      unique case (s_reg.aw_addr)
        `LHB_ADDR_STATUS: begin
          // read-only word: answered, nothing changes
          upd = '0;
        end
        `LHB_ADDR_FORCE: begin
          upd              = ({25'h0000000, s_reg.force_byp} & ~m) | (s_reg.w_data & m);
          upd              = upd & `LHB_FORCE_MASK;
          s_next.force_byp = upd[6:0];
        end
        `LHB_ADDR_ISTAT: begin
          upd = s_reg.w_data & m & `LHB_EV_MASK;
          clr = upd[15:0];
        end
        `LHB_ADDR_IMASK: begin
          upd             = ({16'h0000, s_reg.int_mask} & ~m) | (s_reg.w_data & m);
          upd             = upd & `LHB_EV_MASK;
          s_next.int_mask = upd[15:0];
        end
        default: begin
          upd = '0;
        end
      endcase
    end
    s_next.awready = !s_next.aw_have && !s_next.bvalid;
    s_next.wready  = !s_next.w_have && !s_next.bvalid;

    // read channel: one read outstanding at a time
    if (r_fire) begin
      s_next.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = read_word(s_axi_araddr, s_reg, present, stream_ok, inserted, mod_bad);
      if (is_mapped(s_axi_araddr)) begin
        s_next.rresp = `LHB_RESP_OKAY;
      end else begin
        // unmapped: zero data, error answer
        s_next.rresp = `LHB_RESP_SLVERR;
      end
    end
    s_next.arready = !s_next.rvalid;

    // bypass re-judged every cycle from synchronised inputs
    s_next.bypass   = byp_cond;
    // an event in the clearing cycle survives: set wins
    s_next.int_stat = (s_reg.int_stat & ~clr) | ev;
    s_next.irq      = |(s_next.int_stat & s_next.int_mask);

    s_next.tx    = fwd;
    s_next.green = lamp_green;
    s_next.amber = lamp_amber;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_reg          <= '0;
      s_reg.bypass   <= `LHB_RST_BYPASS;
      s_reg.int_mask <= `LHB_RST_MASK;
      s_reg.bresp    <= `LHB_RESP_OKAY;
      s_reg.rresp    <= `LHB_RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

  assign s_axi_awready = s_reg.awready;
  assign s_axi_wready  = s_reg.wready;
  assign s_axi_bresp   = s_reg.bresp;
  assign s_axi_bvalid  = s_reg.bvalid;
  assign s_axi_arready = s_reg.arready;
  assign s_axi_rdata   = s_reg.rdata;
  assign s_axi_rresp   = s_reg.rresp;
  assign s_axi_rvalid  = s_reg.rvalid;
  assign tx_serial     = s_reg.tx;
  assign led_green     = s_reg.green;
  assign led_amber     = s_reg.amber;
  assign irq           = s_reg.irq;
endmodule

// ### core/lhb_stream_mon.sv
// per-port serial stream validity monitor
// assumes a synchronised sample of the stream each cycle
`timescale 1ns/1ps
module lhb_stream_mon
  import lhb_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic nrst,
  // stream
  input  wire logic rx,
  output logic      valid
);
`include "lhb_map.svh"

  lhb_mon_t s_reg;
  lhb_mon_t s_next;
  logic     edge_seen;

  assign edge_seen = rx != s_reg.prev;

  always_comb begin
    s_next      = s_reg;
    s_next.prev = rx;
    if (edge_seen) begin
      s_next.run = 6'h00;
      if (s_reg.edges != 7'h7F) begin
        s_next.edges = s_reg.edges + 7'h01;
      end
      // one-cycle pulse counts as jitter
      if (s_reg.run == 6'h00 && s_reg.glitch != 4'hF) begin
        s_next.glitch = s_reg.glitch + 4'h1;
      end
    end else if (s_reg.run != `LHB_RUN_MAX) begin
      s_next.run = s_reg.run + 6'h01;
    end
    if (s_reg.win == `LHB_WIN_LAST) begin
      // off frequency or jittery over the window
      s_next.valid  = s_reg.edges >= `LHB_EDGE_MIN && s_reg.edges <= `LHB_EDGE_MAX
                      && s_reg.glitch <= `LHB_GLITCH_MAX;
      s_next.win    = 7'h00;
      s_next.edges  = 7'h00;
      s_next.glitch = 4'h0;
    end else begin
      s_next.win = s_reg.win + 7'h01;
    end
    // a run of 32 cycles with no transition drops validity at once, not at window end
    if (s_reg.run == `LHB_RUN_MAX) begin
      s_next.valid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign valid = s_reg.valid;
endmodule

// ### core/lhb_sync.sv
// two-flop synchroniser for a group of level inputs
// assumes inputs arrive from outside the clock domain
`timescale 1ns/1ps
module lhb_sync #(
  parameter int W = 7
) (
  // clock and reset
  input  wire logic         clock,
  input  wire logic         nrst,
  // levels
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } lhb_sync_t;

  lhb_sync_t s_reg;
  lhb_sync_t s_next;

  always_comb begin
    s_next.meta   = din;
    s_next.stable = s_reg.meta;
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign dout = s_reg.stable;
endmodule

// ### inc/lhb_map.svh
// constants of the loop hub port bypass block
// included by the package user files; definitions only
`ifndef LHB_MAP_SVH
`define LHB_MAP_SVH

`define LHB_NPORT        7
// register byte offsets
`define LHB_ADDR_STATUS  8'h00
`define LHB_ADDR_FORCE   8'h04
`define LHB_ADDR_ISTAT   8'h08
`define LHB_ADDR_IMASK   8'h0C
// field positions
`define LHB_ST_PRES_LSB  0
`define LHB_ST_INS_LSB   8
`define LHB_ST_VALID_LSB 16
`define LHB_ST_FAULT_LSB 24
`define LHB_EV_INS_LSB   0
`define LHB_EV_BYP_LSB   8
`define LHB_FORCE_MASK   32'h0000007F
`define LHB_EV_MASK      32'h00007F7F
// reset values and answers
`define LHB_RST_BYPASS   7'h7F
`define LHB_RST_MASK     16'h0000
`define LHB_RESP_OKAY    2'h0
`define LHB_RESP_SLVERR  2'h2
// stream monitor counts: window and run in clock cycles, edges and glitches in transitions
`define LHB_WIN_LAST     7'h3F
`define LHB_EDGE_MIN     7'h04
`define LHB_EDGE_MAX     7'h30
`define LHB_RUN_MAX      6'h20
`define LHB_GLITCH_MAX   4'h8

`endif

// ### inc/lhb_pkg.sv
// types shared by the loop hub port bypass files
// assumes lhb_map.svh for the constants
package lhb_pkg;
  typedef logic [6:0]  lhb_port_t;
  typedef logic [15:0] lhb_ev_t;

  typedef struct packed {
    logic        prev;
    logic [5:0]  run;
    logic [6:0]  win;
    logic [6:0]  edges;
    logic [3:0]  glitch;
    logic        valid;
  } lhb_mon_t;

  typedef struct packed {
    logic        aw_have;
    logic [7:0]  aw_addr;
    logic        w_have;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    lhb_port_t   force_byp;
    lhb_ev_t     int_stat;
    lhb_ev_t     int_mask;
    lhb_port_t   bypass;
    lhb_port_t   tx;
    lhb_port_t   green;
    lhb_port_t   amber;
    logic        irq;
  } lhb_state_t;
endpackage

// ### tb/lhb_hub_chk.sv
// port-level assertions for the loop hub port bypass block
// assumes binding onto lhb_hub, one clock, synchronous reset
`timescale 1ns/1ps
module lhb_hub_chk (
  // clock and reset
  input wire logic       clock,
  input wire logic       nrst,
  // bus handshakes
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // module pins and port outputs
  input wire logic [6:0] module_presence_detect,
  input wire logic [6:0] tx_fault,
  input wire logic [6:0] rx_signal_loss,
  input wire logic [6:0] tx_serial,
  input wire logic [6:0] led_green,
  input wire logic [6:0] led_amber
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!nrst);

  // cycles since release; pin history before it is not trusted
  logic [5:0] age_reg;
  always_ff @(posedge clock) begin
    if (!nrst)
      age_reg <= 6'h00;
    else if (age_reg != 6'h3F)
      age_reg <= age_reg + 6'h01;
  end

  property p_green;
    age_reg > 6'h05 |-> led_green == ($past(module_presence_detect, 3) & ~$past(tx_fault, 3));
  endproperty
  a_green: assert property (p_green) else $error("green lamp off its pins");
  property p_fault;
    age_reg > 6'h05 |->
      ($past(tx_fault, 3) & $past(module_presence_detect, 3) & ~led_amber) == 7'h00;
  endproperty
  a_fault: assert property (p_fault) else $error("faulty module not bypassed");
  property p_los;
    age_reg > 6'h05 |->
      ($past(rx_signal_loss, 3) & $past(module_presence_detect, 3) & ~led_amber) == 7'h00;
  endproperty
  a_los: assert property (p_los) else $error("lost signal not bypassed");
  property p_amber;
    age_reg > 6'h05 |-> (led_amber & ~$past(module_presence_detect, 3)) == 7'h00;
  endproperty
  a_amber: assert property (p_amber) else $error("amber lit on empty port");
  property p_reset;
    $rose(nrst) |-> (tx_serial | led_green | led_amber) == 7'h00;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_quiet;
    age_reg < 6'h3C |-> tx_serial == 7'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("port inserted before a full window");
  property p_fwd;
    tx_serial != 7'h00 |-> ($past(led_green) & ~$past(led_amber)) != 7'h00;
  endproperty
  a_fwd: assert property (p_fwd) else $error("data sent with no port inserted");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_wexcl;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_wexcl: assert property (p_wexcl) else $error("write taken while response pending");

  c_both: cover property ((led_green & led_amber) != 7'h00);
  c_fwd: cover property (tx_serial != 7'h00);
  c_wr: cover property (s_axi_bvalid);
endmodule

bind lhb_hub lhb_hub_chk lhb_hub_chk_i (.clock, .nrst, .s_axi_awready, .s_axi_wready,
  .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .module_presence_detect,
  .tx_fault, .rx_signal_loss, .tx_serial, .led_green, .led_amber);

// ### tb/lhb_hub_tb.sv
// self-checking bench for the loop hub port bypass block
// assumes the node model on the module side and the checker bound in
`timescale 1ns/1ps
`include "lhb_map.svh"
module lhb_hub_tb;
  logic        clock;
  logic        nrst;
  logic [7:0]  awaddr, araddr, seed;
  logic        awvalid, wvalid, bready, arvalid, rready, look, fwd_on;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic [6:0]  plug, fault, los, ins_e, h1, h2, h3;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic [6:0]  pres, txf, rxl, rxs, txs, grn, amb;
  logic [1:0]  bq[$];
  logic [33:0] rq[$];
  logic [14:0] lq[$];
  int          num_errors = 0;
  int          total_checks = 0;

  lhb_hub lhb_hub_i (.clock(clock), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .module_presence_detect(pres), .tx_fault(txf), .rx_signal_loss(rxl),
    .rx_serial(rxs), .tx_serial(txs), .led_green(grn), .led_amber(amb), .irq(irq));
  lhb_node_model lhb_node_model_i (.clock(clock), .plug(plug), .fault(fault), .los(los),
    .module_presence_detect(pres), .tx_fault(txf), .rx_signal_loss(rxl), .rx_serial(rxs));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // nearest inserted port upstream wins; own port comes last
  function automatic logic [6:0] ring(input logic [6:0] rx, input logic [6:0] ins);
    logic [6:0] o;
    o = 7'h00;
    for (int j = 0; j < 7; j++)
      for (int d = 7; d > 0; d--)
        if (ins[(j + 7 - d) % 7]) o[j] = rx[(j + 7 - d) % 7];
    return o;
  endfunction

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clock);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    @(posedge clock);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic leds(input logic [14:0] e);
    @(posedge clock);
    lq.push_back(e);
    look <= 1'b1;
    @(posedge clock);
    look <= 1'b0;
  endtask

  // forwarding is only judged once the port set has settled
  task automatic hold(input int n, input logic [6:0] ins);
    repeat (n) @(posedge clock);
    ins_e = ins;
    fwd_on = 1'b1;
    repeat (30) @(posedge clock);
    fwd_on = 1'b0;
  endtask

  always @(posedge clock) begin
    if (bvalid && bready) chk(34'(bresp), 34'(bq.pop_front()));
    if (rvalid && rready) chk({rresp, rdata}, rq.pop_front());
    if (look) chk(34'({irq, grn, amb}), 34'(lq.pop_front()));
    h1 <= rxs;
    h2 <= h1;
    h3 <= h2;
  end

  always @(negedge clock)
    if (fwd_on) chk(34'(txs), 34'(ring(h3, ins_e)));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  initial begin
    #20000;
    num_errors++;
    close_out;
  end

  initial begin
    nrst = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, look, fwd_on} = 7'h00;
    {awaddr, araddr, wdata, ins_e} = 55'h0;
    seed = 8'h21;
    wstrb = 4'hF;
    plug = 7'h5F;
    fault = 7'h40;
    los = 7'h00;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    repeat (4) @(posedge clock);
    rd(`LHB_ADDR_STATUS, 34'h04000005F);
    repeat (150) @(posedge clock);
    rd(`LHB_ADDR_STATUS, 34'h0405F1F5F);
    leds(15'h0FC0);
    hold(4, 7'h1F);
    los[2] <= 1'b1;
    hold(8, 7'h1B);
    leds(15'h0FC4);
    plug[3] <= 1'b0;
    hold(8, 7'h13);
    leds(15'h0BC4);
    wr(`LHB_ADDR_FORCE, 32'hFFFFFF81, `LHB_RESP_OKAY);
    hold(6, 7'h12);
    leds(15'h0BC5);
    rd(`LHB_ADDR_FORCE, 34'h000000001);
    rd(`LHB_ADDR_ISTAT, 34'h000000D1F);
    for (int i = 0; i < 3; i++) begin
      seed = lfsr(seed);
      wr(`LHB_ADDR_IMASK, {4{seed}}, `LHB_RESP_OKAY);
      rd(`LHB_ADDR_IMASK, {2'h0, {4{seed}} & `LHB_EV_MASK});
    end
    // one byte lane only: the other lane keeps its last value
    wstrb <= 4'h2;
    wr(`LHB_ADDR_IMASK, 32'hFFFFFFFF, `LHB_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`LHB_ADDR_IMASK, {18'h00000, 8'h7F, 1'b0, seed[6:0]});
    wr(`LHB_ADDR_IMASK, 32'h00000100, `LHB_RESP_OKAY);
    leds(15'h4BC5);
    wr(`LHB_ADDR_ISTAT, 32'h00000100, `LHB_RESP_OKAY);
    leds(15'h0BC5);
    rd(`LHB_ADDR_ISTAT, 34'h000000C1F);
    wr(8'h10, 32'h00000001, `LHB_RESP_SLVERR);
    rd(8'h10, {`LHB_RESP_SLVERR, 32'h00000000});
    wr(`LHB_ADDR_FORCE, 32'h00000000, `LHB_RESP_OKAY);
    plug[3] <= 1'b1;
    los[2] <= 1'b0;
    repeat (10) @(posedge clock);
    leds(15'h0FCC);
    hold(150, 7'h1F);
    rd(`LHB_ADDR_STATUS, 34'h0405F1F5F);
    leds(15'h0FC0);
    close_out;
  end
endmodule

// ### tb/lhb_node_model.sv
// transceiver modules and loop nodes on the seven hub ports
// assumes the bench commands fitting, faults and signal loss per port
`timescale 1ns/1ps
module lhb_node_model (
  // clock
  input  wire logic       clock,
  // bench commands
  input  wire logic [6:0] plug,
  input  wire logic [6:0] fault,
  input  wire logic [6:0] los,
  // transceiver pins
  output logic      [6:0] module_presence_detect,
  output logic      [6:0] tx_fault,
  output logic      [6:0] rx_signal_loss,
  output logic      [6:0] rx_serial
);
  logic [15:0] cnt_reg = 16'h0000;
  assign module_presence_detect = plug;
  // an empty slot has no fault driver; pulled inactive
  assign tx_fault = fault & plug;
  assign rx_signal_loss = los;
  // distinct half periods per port so a misrouted stream shows
  always @(posedge clock) begin
    cnt_reg <= cnt_reg + 16'h0001;
    for (int i = 0; i < 7; i++)
      rx_serial[i] <= (plug[i] && !los[i]) ? 1'((cnt_reg / 16'(i + 2)) & 16'h0001)
                                           : cnt_reg[0];
  end
endmodule
